// ### design/rtcs_entry_track.sv
`timescale 1ns/1ps
module rtcs_entry_track #(
  parameter int W = 4
) (
  input wire logic clk, // register clock
  input wire logic rst, // synchronous reset
  input wire logic [W-1:0] prog, // register programmed this cycle
  input wire logic [W-1:0] bad, // programmed data is invalid
  output logic [W-1:0] invalid // invalid since last programmed
);
  logic [W-1:0] next_invalid;

  // each programming replaces the verdict; between writes it holds
  assign next_invalid = (prog & bad) | (~prog & invalid);

  always_ff @(posedge clk) begin
    if (rst) begin
      invalid <= '0;
    end else begin
      invalid <= next_invalid;
    end
  end
endmodule

// ### design/rtcs_flag_bank.sv
`timescale 1ns/1ps
module rtcs_flag_bank #(
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // register clock
  input wire logic rst, // synchronous reset
  input wire logic [W-1:0] set, // per-bit set
  input wire logic [W-1:0] clr, // per-bit clear
  output logic [W-1:0] flags // held flags
);
  logic [W-1:0] next_flags;

  // a set arriving with its clear wins, so no event is lost
  assign next_flags = (flags & ~clr) | set;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= INIT;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// ### design/rtcs_pkg.sv
package rtcs_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int NFLAG = 6;
  localparam int NMASK_RD = 5;
  localparam int NVALID = 4;

  // byte addresses of the register words
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 32'h400E1478;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_CLEAR = 32'h400E147C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 32'h400E1480;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_DISABLE = 32'h400E1484;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 32'h400E1488;
  localparam logic [ADDR_W-1:0] ADDR_VALID_ENTRY = 32'h400E148C;

  // flag positions shared by status, clear, enable, disable and mask
  localparam int BIT_ACK = 0;
  localparam int BIT_ALARM = 1;
  localparam int BIT_SECOND = 2;
  localparam int BIT_TIME = 3;
  localparam int BIT_CAL = 4;
  localparam int BIT_ERR = 5;

  // valid-entry positions
  localparam int BIT_NV_TIME = 0;
  localparam int BIT_NV_CAL = 1;
  localparam int BIT_NV_TALR = 2;
  localparam int BIT_NV_CALR = 3;

  localparam logic [NFLAG-1:0] FLAGS_RESET = 6'h00;
  localparam logic [NFLAG-1:0] MASK_RESET = 6'h00;
  localparam logic [NVALID-1:0] VALID_RESET = 4'h0;

  // field layout of the time word
  localparam int TM_SEC_LSB = 0;
  localparam int TM_MIN_LSB = 8;
  localparam int TM_HOUR_LSB = 16;
  localparam int TM_AMPM = 22;
  localparam int TA_SEC_EN = 7;
  localparam int TA_MIN_EN = 15;
  localparam int TA_HOUR_EN = 23;

  // field layout of the calendar word
  localparam int CL_CENT_LSB = 0;
  localparam int CL_YEAR_LSB = 8;
  localparam int CL_MONTH_LSB = 16;
  localparam int CL_DAY_LSB = 21;
  localparam int CL_DATE_LSB = 24;
  localparam int CA_MONTH_EN = 23;
  localparam int CA_DATE_EN = 31;

  // bcd limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_MAX_MINSEC = 8'h59;
  localparam logic [7:0] BCD_MAX_H24 = 8'h23;
  localparam logic [7:0] BCD_MAX_H12 = 8'h12;
  localparam logic [7:0] BCD_MIN_CENT = 8'h19;
  localparam logic [7:0] BCD_MAX_CENT = 8'h20;
  localparam logic [7:0] BCD_MAX_YEAR = 8'h99;
  localparam logic [7:0] BCD_MAX_MONTH = 8'h12;
  localparam logic [7:0] BCD_MAX_DAY = 8'h07;
  localparam logic [7:0] BCD_MAX_DATE = 8'h31;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ### design/rtcs_status_irq.sv
// Functional notes
// - error flag set while counters invalid, sticky
// - error flag reads zero after valid interval
// - clear register ones clear matching status flags
// - enable register ones enable matching sources
// - enable bit five enables error source
// - disable register ones disable matching sources
// - disable bit five disables error source
// - mask register shows enabled sources, bits 0-4
// - bit0 flags invalid time register data
// - bit1 flags invalid calendar register data
// - bit2 flags invalid time alarm data
// - bit3 flags invalid calendar alarm data
// - second, time, calendar flags sticky until cleared
// - acknowledge flag high while updates allowed
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module rtcs_status_irq (
  input wire logic clk, // register clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [rtcs_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [rtcs_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [rtcs_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [rtcs_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic update_allowed, // level: time/calendar may be updated
  input wire logic alarm_event, // pulse: alarm match
  input wire logic second_event, // pulse: second tick
  input wire logic time_event, // pulse: selected time event
  input wire logic calendar_event, // pulse: selected calendar event
  input wire logic hour_mode_12, // level: 12-hour mode selected
  input wire logic [31:0] run_time, // running time counters
  input wire logic [31:0] run_date, // running calendar counters
  input wire logic time_prog, // pulse: time register programmed
  input wire logic [31:0] time_prog_data, // value programmed into time register
  input wire logic date_prog, // pulse: calendar register programmed
  input wire logic [31:0] date_prog_data, // value programmed into calendar register
  input wire logic talr_prog, // pulse: time alarm programmed
  input wire logic [31:0] talr_prog_data, // value programmed into time alarm
  input wire logic calr_prog, // pulse: calendar alarm programmed
  input wire logic [31:0] calr_prog_data, // value programmed into calendar alarm
  output logic [rtcs_pkg::NFLAG-1:0] status_flags, // status flags
  output logic [rtcs_pkg::NFLAG-1:0] irq_enabled, // enabled sources
  output logic [rtcs_pkg::NVALID-1:0] entry_invalid, // valid-entry flags
  output logic irq // level interrupt, active high
);
  import rtcs_pkg::*;

  function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    // valid digits keep bcd order equal to numeric order
    bcd_in = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  function automatic logic hour_ok(input logic [5:0] h, input logic pm,
                                   input logic m12);
    if (m12) begin
      hour_ok = bcd_in({2'h0, h}, BCD_ONE, BCD_MAX_H12);
    end else begin
      hour_ok = bcd_in({2'h0, h}, BCD_ZERO, BCD_MAX_H24) && !pm;
    end
  endfunction

  function automatic logic time_ok(input logic [31:0] d, input logic m12);
    time_ok = bcd_in({1'h0, d[TM_SEC_LSB +: 7]}, BCD_ZERO, BCD_MAX_MINSEC)
           && bcd_in({1'h0, d[TM_MIN_LSB +: 7]}, BCD_ZERO, BCD_MAX_MINSEC)
           && hour_ok(d[TM_HOUR_LSB +: 6], d[TM_AMPM], m12);
  endfunction

  function automatic logic date_ok(input logic [31:0] d);
    date_ok = bcd_in({1'h0, d[CL_CENT_LSB +: 7]}, BCD_MIN_CENT, BCD_MAX_CENT)
           && bcd_in(d[CL_YEAR_LSB +: 8], BCD_ZERO, BCD_MAX_YEAR)
           && bcd_in({3'h0, d[CL_MONTH_LSB +: 5]}, BCD_ONE, BCD_MAX_MONTH)
           && bcd_in({5'h00, d[CL_DAY_LSB +: 3]}, BCD_ONE, BCD_MAX_DAY)
           && bcd_in({2'h0, d[CL_DATE_LSB +: 6]}, BCD_ONE, BCD_MAX_DATE);
  endfunction

  // alarm fields are judged only while their match is enabled
  function automatic logic talr_ok(input logic [31:0] d, input logic m12);
    logic s_ok;
    logic m_ok;
    logic h_ok;
    s_ok = bcd_in({1'h0, d[TM_SEC_LSB +: 7]}, BCD_ZERO, BCD_MAX_MINSEC);
    m_ok = bcd_in({1'h0, d[TM_MIN_LSB +: 7]}, BCD_ZERO, BCD_MAX_MINSEC);
    h_ok = hour_ok(d[TM_HOUR_LSB +: 6], d[TM_AMPM], m12);
    talr_ok = (!d[TA_SEC_EN] || s_ok) && (!d[TA_MIN_EN] || m_ok)
           && (!d[TA_HOUR_EN] || h_ok);
  endfunction

  function automatic logic calr_ok(input logic [31:0] d);
    logic mo_ok;
    logic da_ok;
    mo_ok = bcd_in({3'h0, d[CL_MONTH_LSB +: 5]}, BCD_ONE, BCD_MAX_MONTH);
    da_ok = bcd_in({2'h0, d[CL_DATE_LSB +: 6]}, BCD_ONE, BCD_MAX_DATE);
    calr_ok = (!d[CA_MONTH_EN] || mo_ok) && (!d[CA_DATE_EN] || da_ok);
  endfunction

  function automatic logic word_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] reg_addr);
    word_hit = (a[ADDR_W-1:2] == reg_addr[ADDR_W-1:2]);
  endfunction

  // write channel holding registers
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [DATA_W-1:0] next_w_data;
  logic [3:0] next_w_strb;

  // read channel registers
  logic rvalid;
  logic [1:0] rresp;
  logic [DATA_W-1:0] rdata;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !bvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  assign next_aw_addr = aw_take ? s_axi_awaddr : aw_addr;
  assign next_w_data = w_take ? s_axi_wdata : w_data;
  assign next_w_strb = w_take ? s_axi_wstrb : w_strb;

  // write decode
  wire wr_clear_hit = word_hit(aw_addr, ADDR_STATUS_CLEAR);
  wire wr_en_hit = word_hit(aw_addr, ADDR_IRQ_ENABLE);
  wire wr_dis_hit = word_hit(aw_addr, ADDR_IRQ_DISABLE);
  wire wr_ro_hit = word_hit(aw_addr, ADDR_STATUS) || word_hit(aw_addr, ADDR_IRQ_MASK)
                || word_hit(aw_addr, ADDR_VALID_ENTRY);
  wire wr_cmd_hit = wr_clear_hit || wr_en_hit || wr_dis_hit;
  // all command bits live in byte lane 0
  wire wr_lane0 = do_write && w_strb[0];
  wire [NFLAG-1:0] wr_bits = w_data[NFLAG-1:0];
  wire wr_clear_go = wr_lane0 && wr_clear_hit;
  wire wr_en_go = wr_lane0 && wr_en_hit;
  wire wr_dis_go = wr_lane0 && wr_dis_hit;

  // one named field per flag; the three command words share the status layout
  wire clear_update_ack = wr_clear_go && wr_bits[BIT_ACK];
  wire clear_alarm_flag = wr_clear_go && wr_bits[BIT_ALARM];
  wire clear_second_flag = wr_clear_go && wr_bits[BIT_SECOND];
  wire clear_time_event_flag = wr_clear_go && wr_bits[BIT_TIME];
  wire clear_calendar_event_flag = wr_clear_go && wr_bits[BIT_CAL];
  wire clear_free_running_error = wr_clear_go && wr_bits[BIT_ERR];
  wire update_ack_irq_on = wr_en_go && wr_bits[BIT_ACK];
  wire alarm_irq_on = wr_en_go && wr_bits[BIT_ALARM];
  wire second_irq_on = wr_en_go && wr_bits[BIT_SECOND];
  wire time_event_irq_on = wr_en_go && wr_bits[BIT_TIME];
  wire calendar_event_irq_on = wr_en_go && wr_bits[BIT_CAL];
  wire error_irq_on = wr_en_go && wr_bits[BIT_ERR];
  wire update_ack_irq_off = wr_dis_go && wr_bits[BIT_ACK];
  wire alarm_irq_off = wr_dis_go && wr_bits[BIT_ALARM];
  wire second_irq_off = wr_dis_go && wr_bits[BIT_SECOND];
  wire time_event_irq_off = wr_dis_go && wr_bits[BIT_TIME];
  wire calendar_event_irq_off = wr_dis_go && wr_bits[BIT_CAL];
  wire error_irq_off = wr_dis_go && wr_bits[BIT_ERR];

  logic [NFLAG-1:0] clear_cmd;
  logic [NFLAG-1:0] enable_cmd;
  logic [NFLAG-1:0] disable_cmd;

  assign clear_cmd[BIT_ACK] = clear_update_ack;
  assign clear_cmd[BIT_ALARM] = clear_alarm_flag;
  assign clear_cmd[BIT_SECOND] = clear_second_flag;
  assign clear_cmd[BIT_TIME] = clear_time_event_flag;
  assign clear_cmd[BIT_CAL] = clear_calendar_event_flag;
  assign clear_cmd[BIT_ERR] = clear_free_running_error;
  assign enable_cmd[BIT_ACK] = update_ack_irq_on;
  assign enable_cmd[BIT_ALARM] = alarm_irq_on;
  assign enable_cmd[BIT_SECOND] = second_irq_on;
  assign enable_cmd[BIT_TIME] = time_event_irq_on;
  assign enable_cmd[BIT_CAL] = calendar_event_irq_on;
  assign enable_cmd[BIT_ERR] = error_irq_on;
  assign disable_cmd[BIT_ACK] = update_ack_irq_off;
  assign disable_cmd[BIT_ALARM] = alarm_irq_off;
  assign disable_cmd[BIT_SECOND] = second_irq_off;
  assign disable_cmd[BIT_TIME] = time_event_irq_off;
  assign disable_cmd[BIT_CAL] = calendar_event_irq_off;
  assign disable_cmd[BIT_ERR] = error_irq_off;
  wire [1:0] wr_resp = wr_cmd_hit ? RESP_OKAY : (wr_ro_hit ? RESP_SLVERR : RESP_DECERR);

  // read decode
  wire rd_status_hit = word_hit(s_axi_araddr, ADDR_STATUS);
  wire rd_mask_hit = word_hit(s_axi_araddr, ADDR_IRQ_MASK);
  wire rd_valid_hit = word_hit(s_axi_araddr, ADDR_VALID_ENTRY);
  wire rd_wo_hit = word_hit(s_axi_araddr, ADDR_STATUS_CLEAR)
                || word_hit(s_axi_araddr, ADDR_IRQ_ENABLE)
                || word_hit(s_axi_araddr, ADDR_IRQ_DISABLE);
  wire rd_ok_hit = rd_status_hit || rd_mask_hit || rd_valid_hit;
  wire status_read = ar_take && rd_status_hit;
  wire [NMASK_RD-1:0] mask_view = irq_enabled[NMASK_RD-1:0];
  wire invalid_time_flag = entry_invalid[BIT_NV_TIME];
  wire invalid_calendar_flag = entry_invalid[BIT_NV_CAL];
  wire invalid_time_alarm_flag = entry_invalid[BIT_NV_TALR];
  wire invalid_calendar_alarm_flag = entry_invalid[BIT_NV_CALR];
  logic [NVALID-1:0] valid_entry_word;
  assign valid_entry_word[BIT_NV_TIME] = invalid_time_flag;
  assign valid_entry_word[BIT_NV_CAL] = invalid_calendar_flag;
  assign valid_entry_word[BIT_NV_TALR] = invalid_time_alarm_flag;
  assign valid_entry_word[BIT_NV_CALR] = invalid_calendar_alarm_flag;
  wire [DATA_W-1:0] rd_word =
      rd_status_hit ? {{(DATA_W-NFLAG){1'b0}}, status_flags} :
      rd_mask_hit ? {{(DATA_W-NMASK_RD){1'b0}}, mask_view} :
      rd_valid_hit ? {{(DATA_W-NVALID){1'b0}}, valid_entry_word} :
      '0;
  wire [1:0] rd_resp = rd_ok_hit ? RESP_OKAY : (rd_wo_hit ? RESP_SLVERR : RESP_DECERR);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
    end else begin
      aw_held <= (aw_held || aw_take) && !do_write;
      w_held <= (w_held || w_take) && !do_write;
      bvalid <= do_write || (bvalid && !s_axi_bready);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      bresp <= RESP_OKAY;
    end else begin
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= do_write ? wr_resp : bresp;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
    end else begin
      rvalid <= ar_take || (rvalid && !s_axi_rready);
      rresp <= ar_take ? rd_resp : rresp;
      rdata <= ar_take ? rd_word : rdata;
    end
  end

  // running counter check; a corrupt value re-raises the flag each cycle
  wire counters_bad = !time_ok(run_time, hour_mode_12) || !date_ok(run_date);

  logic [NFLAG-1:0] flag_set;
  logic [NFLAG-1:0] flag_clr;

  assign flag_set[BIT_ACK] = update_allowed;
  assign flag_set[BIT_ALARM] = alarm_event;
  assign flag_set[BIT_SECOND] = second_event;
  assign flag_set[BIT_TIME] = time_event;
  assign flag_set[BIT_CAL] = calendar_event;
  assign flag_set[BIT_ERR] = counters_bad;

  // a status read also clears; the read data already holds the old flags
  assign flag_clr = clear_cmd | (status_read ? {NFLAG{1'b1}} : '0);

  // set beats clear inside the bank
  rtcs_flag_bank #(
    .W(NFLAG),
    .INIT(FLAGS_RESET)
  ) u_status (
    .clk(clk),
    .rst(rst),
    .set(flag_set),
    .clr(flag_clr),
    .flags(status_flags)
  );

  // source enables: ones enable, ones disable, zeros leave alone
  rtcs_flag_bank #(
    .W(NFLAG),
    .INIT(MASK_RESET)
  ) u_enables (
    .clk(clk),
    .rst(rst),
    .set(enable_cmd),
    .clr(disable_cmd),
    .flags(irq_enabled)
  );

  logic [NVALID-1:0] prog;
  logic [NVALID-1:0] prog_bad;

  assign prog[BIT_NV_TIME] = time_prog;
  assign prog[BIT_NV_CAL] = date_prog;
  assign prog[BIT_NV_TALR] = talr_prog;
  assign prog[BIT_NV_CALR] = calr_prog;
  assign prog_bad[BIT_NV_TIME] = !time_ok(time_prog_data, hour_mode_12);
  assign prog_bad[BIT_NV_CAL] = !date_ok(date_prog_data);
  assign prog_bad[BIT_NV_TALR] = !talr_ok(talr_prog_data, hour_mode_12);
  assign prog_bad[BIT_NV_CALR] = !calr_ok(calr_prog_data);

  // verdict stays until the same register is programmed again
  rtcs_entry_track #(
    .W(NVALID)
  ) u_entry (
    .clk(clk),
    .rst(rst),
    .prog(prog),
    .bad(prog_bad),
    .invalid(entry_invalid)
  );

  // registered so the line carries no decode glitches
  logic next_irq;
  assign next_irq = |(status_flags & irq_enabled);

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule

// ### verif/rtcs_status_irq_props.sv
`timescale 1ns/1ps
module rtcs_status_irq_props (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_rvalid, // read data valid
  input wire logic second_event, // second tick
  input wire logic update_allowed, // update window
  input wire logic [31:0] run_time, // live time
  input wire logic time_prog, // time programmed
  input wire logic [rtcs_pkg::NFLAG-1:0] status_flags, // flags
  input wire logic [rtcs_pkg::NFLAG-1:0] irq_enabled, // enables
  input wire logic [rtcs_pkg::NVALID-1:0] entry_invalid, // entry flags
  input wire logic irq // interrupt
);
  import rtcs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // $past guards keep a one-edge reset from looking like a fall or change
  a_irq_level: assert property (
    !$past(rst) |-> irq == |($past(status_flags) & $past(irq_enabled)))
    else $error("irq does not follow enabled flags");
  a_reset_clear: assert property (
    $fell(rst) |-> status_flags == '0 && irq_enabled == '0 && entry_invalid == '0 && !irq)
    else $error("state not cleared by reset");
  a_second_sticky: assert property (
    second_event |=> status_flags[BIT_SECOND])
    else $error("second flag not set");
  a_ack_follow: assert property (
    update_allowed |=> status_flags[BIT_ACK])
    else $error("ack flag not set");
  a_err_detect: assert property (
    run_time[3:0] > 4'h9 |=> status_flags[BIT_ERR])
    else $error("error flag not set");
  a_flag_hold: assert property (
    !$past(rst) && |($past(status_flags) & ~status_flags)
      |-> $rose(s_axi_bvalid) || $rose(s_axi_rvalid))
    else $error("flag dropped without clear or read");
  a_enable_hold: assert property (
    !$past(rst) && $changed(irq_enabled) |-> $rose(s_axi_bvalid))
    else $error("enables changed without write");
  a_entry_hold: assert property (
    !$past(rst) && $changed(entry_invalid[BIT_NV_TIME]) |-> $past(time_prog))
    else $error("time entry flag changed without programming");
endmodule
bind rtcs_status_irq rtcs_status_irq_props i_props (.clk(clk), .rst(rst),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid), .second_event(second_event),
  .update_allowed(update_allowed), .run_time(run_time), .time_prog(time_prog),
  .status_flags(status_flags), .irq_enabled(irq_enabled), .entry_invalid(entry_invalid),
  .irq(irq));

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rtcs_pkg::*;
  logic clk = 0, rst = 1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [31:0] run_time = '0, run_date = 32'h0121_2420, time_prog_data = '0;
  logic [31:0] date_prog_data = '0, talr_prog_data = '0, calr_prog_data = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hF, ve = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, update_allowed = 0, alarm_event = 0, second_event = 0;
  logic time_event = 0, calendar_event = 0, hour_mode_12 = 0;
  logic time_prog = 0, date_prog = 0, talr_prog = 0, calr_prog = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NFLAG-1:0] status_flags, irq_enabled;
  logic [NVALID-1:0] entry_invalid;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] seed = 32'h761C, en;
  int fail_count = 0, n_checks = 0, cycles = 0;

  rtcs_status_irq i_dut (.*);

  always #4 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic fail(input string m);
    fail_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic finish_test();
    if (rq.size() + bq.size() != 0) fail("answer missing");
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // sample at the falling edge so readies never race the launching edge
  always @(negedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      n_checks++;
      if (rq.size() == 0 || {s_axi_rresp, s_axi_rdata} !== rq.pop_front()) fail("read data");
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n_checks++;
      if (bq.size() == 0 || s_axi_bresp !== bq.pop_front()) fail("write response");
    end
    if (++cycles > 20000) begin
      fail("timeout");
      finish_test();
    end
  end

  // waits for the answer: 0 address taken, 1 read data, 2 write response
  task automatic wt(input int k);
    logic h;
    do begin
      @(negedge clk);
      h = (k == 0) ? s_axi_arready : ((k == 1) ? s_axi_rvalid : s_axi_bvalid);
      @(posedge clk);
    end while (!h);
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [1:0] e = RESP_OKAY);
    logic ha, hw;
    @(posedge clk);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    {ha, hw} = 2'h0;
    // address and data may be taken on different edges; drop each on its own
    while (!(ha && hw)) begin
      @(negedge clk);
      if (s_axi_awvalid && s_axi_awready) ha = 1;
      if (s_axi_wvalid && s_axi_wready) hw = 1;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 0;
      if (hw) s_axi_wvalid <= 0;
    end
    wt(2);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [31:0] a, d, input logic [1:0] e = RESP_OKAY);
    @(posedge clk);
    rq.push_back({e, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    wt(0);
    s_axi_arvalid <= 0;
    wt(1);
    s_axi_rready <= 0;
  endtask

  task automatic chk(input logic v);
    // irq is registered, so it trails the flag and the enable by one edge
    @(posedge clk);
    @(negedge clk);
    n_checks++;
    if (irq !== v) fail("irq level");
  endtask

  // one cycle of every event source, ack window and a bad seconds digit
  task automatic set_all();
    @(posedge clk);
    {update_allowed, alarm_event, second_event, time_event, calendar_event} <= 5'h1F;
    run_time <= 32'h0000_005A;
    @(posedge clk);
    {update_allowed, alarm_event, second_event, time_event, calendar_event} <= 5'h00;
    run_time <= '0;
  endtask

  task automatic prog(input int k, input logic [31:0] v, input logic b);
    @(posedge clk);
    {time_prog_data, date_prog_data, talr_prog_data, calr_prog_data} <= {4{v}};
    {calr_prog, talr_prog, date_prog, time_prog} <= 4'h1 << k;
    @(posedge clk);
    {calr_prog, talr_prog, date_prog, time_prog} <= 4'h0;
    ve[k] = b;
    rd(ADDR_VALID_ENTRY, {28'h0, ve});
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(ADDR_IRQ_MASK, '0);
    rd(ADDR_VALID_ENTRY, '0);
    rd(ADDR_STATUS, '0);
    for (int i = 0; i < 6; i++) begin
      set_all();
      chk(0);
      wr(ADDR_IRQ_ENABLE, 32'h1 << i);
      chk(1);
      wr(ADDR_IRQ_DISABLE, 32'h3F);
      chk(0);
      wr(ADDR_STATUS_CLEAR, 32'h1 << i);
      rd(ADDR_STATUS, 32'h3F ^ (32'h1 << i));
    end
    set_all();
    wr(ADDR_STATUS_CLEAR, 32'h0);
    rd(ADDR_STATUS, 32'h3F);
    run_time <= 32'h0000_5A00;
    update_allowed <= 1;
    rd(ADDR_STATUS, 32'h21);
    rd(ADDR_STATUS, 32'h21);
    run_time <= '0;
    update_allowed <= 0;
    rd(ADDR_STATUS, 32'h21);
    rd(ADDR_STATUS, 32'h00);
    en = '0;
    repeat (4) begin
      seed = xs(seed);
      wr(ADDR_IRQ_ENABLE, seed);
      en |= seed & 32'h3F;
      rd(ADDR_IRQ_MASK, en & 32'h1F);
      seed = xs(seed);
      wr(ADDR_IRQ_DISABLE, seed);
      en &= ~seed;
      rd(ADDR_IRQ_MASK, en & 32'h1F);
    end
    prog(0, 32'h0000_005A, 1);
    prog(0, 32'h0012_0000, 0);
    hour_mode_12 <= 1;
    prog(0, 32'h0000_0000, 1);
    hour_mode_12 <= 0;
    prog(1, 32'h0000_0000, 1);
    prog(1, 32'h0121_2420, 0);
    prog(2, 32'h0000_00DA, 1);
    prog(2, 32'h0000_005A, 0);
    prog(3, 32'h8000_0000, 1);
    prog(3, 32'h0080_0000, 1);
    prog(3, 32'h0000_0000, 0);
    wr(ADDR_IRQ_MASK, 32'h3F, RESP_SLVERR);
    rd(ADDR_IRQ_MASK, en & 32'h1F);
    rd(ADDR_IRQ_ENABLE, '0, RESP_SLVERR);
    wr(ADDR_VALID_ENTRY + 32'h4, '1, RESP_DECERR);
    rd(ADDR_VALID_ENTRY + 32'h4, '0, RESP_DECERR);
    wr(ADDR_IRQ_ENABLE, 32'h3F);
    set_all();
    chk(1);
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    chk(0);
    rd(ADDR_IRQ_MASK, '0);
    rd(ADDR_VALID_ENTRY, '0);
    rd(ADDR_STATUS, '0);
    finish_test();
  end
endmodule
